// ### acs_pkg.sv
package acs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ACS_OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] ACS_OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] ACS_OFF_RESULT = 8'h08;
  localparam logic [7:0] ACS_OFF_STATUS = 8'h0C;
  localparam logic [7:0] ACS_OFF_SER_DATA = 8'h10;
  localparam logic [7:0] ACS_OFF_OFS_COEF = 8'h14;
  localparam logic [7:0] ACS_OFF_GAIN_COEF = 8'h18;

  // ----------------------------------------------------------------
  // conv_ctrl_one fields
  // ----------------------------------------------------------------
  localparam int ACS_C1_EXT_TRIG = 0;
  localparam int ACS_C1_TMR_TRIG = 1;
  localparam int ACS_C1_ACQ_LO = 2;
  localparam int ACS_C1_DIV_LO = 4;
  localparam int ACS_C1_REF_EXT = 6;
  localparam logic [7:0] ACS_C1_RESET = 8'h00;

  // ----------------------------------------------------------------
  // conv_ctrl_two fields
  // ----------------------------------------------------------------
  localparam int ACS_C2_CHAN_LO = 0;
  localparam int ACS_C2_SINGLE = 4;
  localparam int ACS_C2_CONT = 5;
  localparam int ACS_C2_CAPTURE = 6;
  localparam logic [7:0] ACS_C2_RESET = 8'h00;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int ACS_ST_BUSY = 0;
  localparam int ACS_ST_CAL_DONE = 1;
  localparam int ACS_ST_UNREAD = 2;
  localparam int ACS_ST_LOST = 3;
  localparam int ACS_ST_OVERRUN = 4;
  localparam int ACS_ST_SER_BUSY = 5;

  // ----------------------------------------------------------------
  // converter timing
  // ----------------------------------------------------------------
  localparam logic [4:0] ACS_DIV8_M1 = 5'h07;
  localparam logic [4:0] ACS_DIV4_M1 = 5'h03;
  localparam logic [4:0] ACS_DIV16_M1 = 5'h0F;
  localparam logic [4:0] ACS_DIV32_M1 = 5'h1F;
  localparam logic [1:0] ACS_TEMP_ACQ_M1 = 2'h3;
  localparam logic [3:0] ACS_APPROX_LAST = 4'hE;
  localparam logic [3:0] ACS_SAR_LAST = 4'hB;
  localparam logic [11:0] ACS_SAR_MID = 12'h800;
  localparam logic [3:0] ACS_TEMP_CHAN = 4'h8;
  localparam logic [3:0] ACS_SER_LAST = 4'hF;
  localparam logic [15:0] ACS_SER_RESET = 16'h0000;

  typedef enum logic [1:0] {ACS_RESP_OKAY = 2'b00, ACS_RESP_SLVERR = 2'b10} acs_resp_t;

endpackage : acs_pkg

// ### acs_top.sv
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Operation
// - bit 6 selects external reference
// - converter clock is core divided
// - acquisition lasts 1 to 4 converter clocks
// - approximation takes fifteen converter clocks
// - start waits for next converter clock
// - temperature channel forces /32, four clocks
// - single bit converts once, self clears
// - continuous bit converts back to back
// - bit 0 enables start pin rising edge
// - bit 1 enables timer overflow start
// - capture bit moves results to serial register
// - transfer must end before next conversion
// - serialise msb first, channel then result
// - capture disables normal serial and port
// - calibration coefficients load after reset
module acs_top #(
  parameter int SER_HALF = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_start_n,
  input wire logic timer2_ovf,
  input wire logic sar_cmp_hi,
  output logic converter_clock,
  output logic sar_track,
  output logic [11:0] sar_dac_code,
  output logic ref_ext_sel,
  output logic normal_serial_disable,
  output logic ser_sclk,
  output logic ser_mosi,
  output logic ser_cs_n,
  output logic nv_rd_en,
  output logic nv_rd_sel_gain,
  input wire logic [13:0] nv_rd_data,
  input wire logic nv_rd_valid,
  output logic [13:0] offset_coef,
  output logic [13:0] gain_coef
);
  import acs_pkg::*;

  generate
    if (SER_HALF < 1 || SER_HALF > 255) begin : g_bad_ser_half
      $error("SER_HALF must lie in 1..255");
    end
  endgenerate

  typedef enum logic [2:0] {ACS_IDLE, ACS_SYNC, ACS_ACQ, ACS_CONV, ACS_DONE} acs_state_t;
  typedef enum logic [2:0] {ACS_CAL_REQ_OFS, ACS_CAL_WAIT_OFS, ACS_CAL_REQ_GAIN,
                            ACS_CAL_WAIT_GAIN, ACS_CAL_DONE} acs_cal_t;

  logic [7:0] ctrl_one_ff;
  logic [7:0] ctrl_two_ff;
  logic [7:0] aw_addr_ff;
  logic aw_got_ff;
  logic [7:0] w_data_ff;
  logic w_strb0_ff;
  logic w_got_ff;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rd_word;
  logic rd_err;
  logic st_clr_lost;
  logic st_clr_ovr;
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
  logic cmp_s1_ff, cmp_s2_ff;
  logic trig_pend_ff;
  logic [4:0] div_cnt_ff;
  logic [4:0] ratio_m1;
  logic [1:0] acq_m1;
  logic tick;
  logic temp_sel;
  acs_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [3:0] conv_chan_ff;
  logic [11:0] result_ff;
  logic [3:0] result_chan_ff;
  logic unread_ff;
  logic lost_ff;
  logic overrun_ff;
  logic [3:0] sar_bit;
  acs_cal_t cal_ff;
  logic [15:0] ser_data_ff;
  logic [15:0] ser_shift_ff;
  logic ser_busy_ff;
  logic [3:0] ser_bit_ff;
  logic [7:0] ser_hcnt_ff;
  logic start_req;
  logic done_now;
  logic [5:0] wa;
  logic [5:0] ra;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign wa = aw_addr_ff[7:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        aw_got_ff <= 1'b0;
      end
      s_axi_awready <= !aw_got_ff && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff <= 1'b0;
      w_data_ff <= 8'h00;
      w_strb0_ff <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      w_data_ff <= s_axi_wdata[7:0];
      w_strb0_ff <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        w_got_ff <= 1'b0;
      end
      s_axi_wready <= !w_got_ff && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ACS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (wa == ACS_OFF_CTRL_ONE[7:2] || wa == ACS_OFF_CTRL_TWO[7:2]
          || wa == ACS_OFF_STATUS[7:2]) begin
        s_axi_bresp <= ACS_RESP_OKAY;
      end else begin
        s_axi_bresp <= ACS_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign st_clr_lost = wr_fire && w_strb0_ff && wa == ACS_OFF_STATUS[7:2]
                       && w_data_ff[ACS_ST_LOST];
  assign st_clr_ovr = wr_fire && w_strb0_ff && wa == ACS_OFF_STATUS[7:2]
                      && w_data_ff[ACS_ST_OVERRUN];

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_ff <= ACS_C1_RESET;
    end else if (wr_fire && w_strb0_ff && wa == ACS_OFF_CTRL_ONE[7:2]) begin
      ctrl_one_ff <= w_data_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_two_ff <= ACS_C2_RESET;
    end else if (wr_fire && w_strb0_ff && wa == ACS_OFF_CTRL_TWO[7:2]) begin
      ctrl_two_ff <= w_data_ff;
    end else if (done_now) begin
      ctrl_two_ff[ACS_C2_SINGLE] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_ext_sel <= 1'b0;
      normal_serial_disable <= 1'b0;
    end else begin
      ref_ext_sel <= ctrl_one_ff[ACS_C1_REF_EXT];
      normal_serial_disable <= ctrl_two_ff[ACS_C2_CAPTURE];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign ra = s_axi_araddr[7:2];

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (ra == ACS_OFF_CTRL_ONE[7:2]) begin
      rd_word[7:0] = ctrl_one_ff;
    end else if (ra == ACS_OFF_CTRL_TWO[7:2]) begin
      rd_word[7:0] = ctrl_two_ff;
    end else if (ra == ACS_OFF_RESULT[7:2]) begin
      rd_word[15:0] = {result_chan_ff, result_ff};
    end else if (ra == ACS_OFF_STATUS[7:2]) begin
      rd_word[ACS_ST_BUSY] = state_ff != ACS_IDLE;
      rd_word[ACS_ST_CAL_DONE] = cal_ff == ACS_CAL_DONE;
      rd_word[ACS_ST_UNREAD] = unread_ff;
      rd_word[ACS_ST_LOST] = lost_ff;
      rd_word[ACS_ST_OVERRUN] = overrun_ff;
      rd_word[ACS_ST_SER_BUSY] = ser_busy_ff;
    end else if (ra == ACS_OFF_SER_DATA[7:2]) begin
      rd_word[15:0] = ser_data_ff;
    end else if (ra == ACS_OFF_OFS_COEF[7:2]) begin
      rd_word[13:0] = offset_coef;
    end else if (ra == ACS_OFF_GAIN_COEF[7:2]) begin
      rd_word[13:0] = gain_coef;
    end else begin
      rd_err = 1'b1;
    end
  end

  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ACS_RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_err ? ACS_RESP_SLVERR : ACS_RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and trigger capture
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_ff <= 1'b1;
      ext_s2_ff <= 1'b1;
      ext_s3_ff <= 1'b1;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else begin
      ext_s1_ff <= ext_start_n;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      cmp_s1_ff <= sar_cmp_hi;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_pend_ff <= 1'b0;
    end else if ((ctrl_one_ff[ACS_C1_EXT_TRIG] && ext_s2_ff && !ext_s3_ff)
                 || (ctrl_one_ff[ACS_C1_TMR_TRIG] && timer2_ovf)) begin
      trig_pend_ff <= 1'b1;
    end else if (state_ff == ACS_IDLE && start_req && cal_ff == ACS_CAL_DONE) begin
      trig_pend_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // converter clock divider
  // ----------------------------------------------------------------
  assign temp_sel = (state_ff == ACS_IDLE ? ctrl_two_ff[3:0] : conv_chan_ff) == ACS_TEMP_CHAN;

  always_comb begin
    ratio_m1 = ACS_DIV8_M1;
    if (temp_sel) begin
      ratio_m1 = ACS_DIV32_M1;
    end else begin
      case (ctrl_one_ff[ACS_C1_DIV_LO +: 2])
        2'b00: ratio_m1 = ACS_DIV8_M1;
        2'b01: ratio_m1 = ACS_DIV4_M1;
        2'b10: ratio_m1 = ACS_DIV16_M1;
        default: ratio_m1 = ACS_DIV32_M1;
      endcase
    end
  end

  assign acq_m1 = temp_sel ? ACS_TEMP_ACQ_M1 : ctrl_one_ff[ACS_C1_ACQ_LO +: 2];
  assign tick = div_cnt_ff >= ratio_m1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_ff <= 5'h00;
      converter_clock <= 1'b0;
    end else begin
      div_cnt_ff <= tick ? 5'h00 : div_cnt_ff + 5'h01;
      if (tick) begin
        converter_clock <= 1'b1;
      end else if (div_cnt_ff == {1'b0, ratio_m1[4:1]}) begin
        converter_clock <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  assign start_req = ctrl_two_ff[ACS_C2_SINGLE] || ctrl_two_ff[ACS_C2_CONT] || trig_pend_ff;
  assign done_now = state_ff == ACS_DONE;
  assign sar_bit = ACS_SAR_LAST - cnt_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ACS_IDLE;
      cnt_ff <= 4'h0;
      conv_chan_ff <= 4'h0;
      sar_track <= 1'b0;
      sar_dac_code <= 12'h000;
    end else begin
      case (state_ff)
        ACS_IDLE: begin
          if (start_req && cal_ff == ACS_CAL_DONE) begin
            conv_chan_ff <= ctrl_two_ff[3:0];
            state_ff <= ACS_SYNC;
          end
        end
        ACS_SYNC: begin
          if (tick) begin
            cnt_ff <= 4'h0;
            sar_track <= 1'b1;
            state_ff <= ACS_ACQ;
          end
        end
        ACS_ACQ: begin
          if (tick) begin
            if (cnt_ff == {2'b00, acq_m1}) begin
              cnt_ff <= 4'h0;
              sar_track <= 1'b0;
              sar_dac_code <= ACS_SAR_MID;
              state_ff <= ACS_CONV;
            end else begin
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
        end
        ACS_CONV: begin
          if (tick) begin
            if (cnt_ff <= ACS_SAR_LAST) begin
              if (!cmp_s2_ff) begin
                sar_dac_code[sar_bit] <= 1'b0;
              end
              if (sar_bit != 4'h0) begin
                sar_dac_code[sar_bit - 4'h1] <= 1'b1;
              end
            end
            if (cnt_ff == ACS_APPROX_LAST) begin
              state_ff <= ACS_DONE;
            end else begin
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
        end
        default: begin
          state_ff <= ACS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ff <= 12'h000;
      result_chan_ff <= 4'h0;
    end else if (done_now) begin
      result_ff <= sar_dac_code;
      result_chan_ff <= conv_chan_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unread_ff <= 1'b0;
    end else if (done_now) begin
      unread_ff <= 1'b1;
    end else if (rd_fire && ra == ACS_OFF_RESULT[7:2]) begin
      unread_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lost_ff <= 1'b0;
    end else if (done_now && unread_ff && !ctrl_two_ff[ACS_C2_CAPTURE]) begin
      lost_ff <= 1'b1;
    end else if (st_clr_lost) begin
      lost_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_ff <= 1'b0;
    end else if (done_now && ctrl_two_ff[ACS_C2_CAPTURE] && ser_busy_ff) begin
      overrun_ff <= 1'b1;
    end else if (st_clr_ovr) begin
      overrun_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // capture serialiser
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_data_ff <= ACS_SER_RESET;
      ser_shift_ff <= ACS_SER_RESET;
      ser_busy_ff <= 1'b0;
      ser_bit_ff <= 4'h0;
      ser_hcnt_ff <= 8'h00;
      ser_sclk <= 1'b0;
      ser_mosi <= 1'b0;
      ser_cs_n <= 1'b1;
    end else if (done_now && ctrl_two_ff[ACS_C2_CAPTURE] && !ser_busy_ff) begin
      ser_data_ff <= {conv_chan_ff, sar_dac_code};
      ser_shift_ff <= {conv_chan_ff, sar_dac_code};
      ser_mosi <= conv_chan_ff[3];
      ser_busy_ff <= 1'b1;
      ser_bit_ff <= 4'h0;
      ser_hcnt_ff <= 8'h00;
      ser_sclk <= 1'b0;
      ser_cs_n <= 1'b0;
    end else if (ser_busy_ff) begin
      if (ser_hcnt_ff == 8'(SER_HALF - 1)) begin
        ser_hcnt_ff <= 8'h00;
        if (!ser_sclk) begin
          ser_sclk <= 1'b1;
        end else begin
          ser_sclk <= 1'b0;
          if (ser_bit_ff == ACS_SER_LAST) begin
            ser_busy_ff <= 1'b0;
            ser_cs_n <= 1'b1;
          end else begin
            ser_bit_ff <= ser_bit_ff + 4'h1;
            ser_mosi <= ser_shift_ff[14];
            ser_shift_ff <= {ser_shift_ff[14:0], 1'b0};
          end
        end
      end else begin
        ser_hcnt_ff <= ser_hcnt_ff + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration coefficient load after reset
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_ff <= ACS_CAL_REQ_OFS;
      nv_rd_en <= 1'b0;
      nv_rd_sel_gain <= 1'b0;
      offset_coef <= 14'h0000;
      gain_coef <= 14'h0000;
    end else begin
      nv_rd_en <= 1'b0;
      case (cal_ff)
        ACS_CAL_REQ_OFS: begin
          nv_rd_en <= 1'b1;
          nv_rd_sel_gain <= 1'b0;
          cal_ff <= ACS_CAL_WAIT_OFS;
        end
        ACS_CAL_WAIT_OFS: begin
          if (nv_rd_valid) begin
            offset_coef <= nv_rd_data;
            cal_ff <= ACS_CAL_REQ_GAIN;
          end
        end
        ACS_CAL_REQ_GAIN: begin
          nv_rd_en <= 1'b1;
          nv_rd_sel_gain <= 1'b1;
          cal_ff <= ACS_CAL_WAIT_GAIN;
        end
        ACS_CAL_WAIT_GAIN: begin
          if (nv_rd_valid) begin
            gain_coef <= nv_rd_data;
            cal_ff <= ACS_CAL_DONE;
          end
        end
        default: begin
          cal_ff <= ACS_CAL_DONE;
        end
      endcase
    end
  end

endmodule : acs_top

// ### acs_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// comparator, coefficient store and capture receiver
// ----------------------------------------------------------------
module acs_far_model #(
  parameter logic [11:0] VIN = 12'hA5C,
  parameter logic [13:0] OFS = 14'h0155,
  parameter logic [13:0] GAIN = 14'h2AAA
) (
  input wire logic aclk,
  input wire logic nv_rd_en,
  input wire logic nv_rd_sel_gain,
  input wire logic [11:0] sar_dac_code,
  input wire logic ser_sclk,
  input wire logic ser_mosi,
  input wire logic ser_cs_n,
  output logic sar_cmp_hi,
  output logic [13:0] nv_rd_data = 14'h0000,
  output logic nv_rd_valid = 1'b0,
  output logic [15:0] rx_word = 16'h0000,
  output logic [7:0] rx_count = 8'h00
);
  logic [2:0] dly_ff = 3'h0;
  logic sel_ff = 1'b0;
  logic sclk_q_ff = 1'b0;
  logic cs_q_ff = 1'b1;
  logic [15:0] sh_ff = 16'h0000;

  // ideal comparator
  assign sar_cmp_hi = VIN >= sar_dac_code;

  // slow answer; data wanders while not valid
  always @(posedge aclk) begin
    dly_ff <= nv_rd_en ? 3'h3 : (dly_ff != 3'h0 ? dly_ff - 3'h1 : 3'h0);
    sel_ff <= nv_rd_en ? nv_rd_sel_gain : sel_ff;
    nv_rd_valid <= dly_ff == 3'h1;
    nv_rd_data <= dly_ff == 3'h1 ? (sel_ff ? GAIN : OFS) : ~nv_rd_data;
  end

  // sample on rising sclk, word ends when select rises
  always @(posedge aclk) begin
    sclk_q_ff <= ser_sclk;
    cs_q_ff <= ser_cs_n;
    if (!ser_cs_n && ser_sclk && !sclk_q_ff) sh_ff <= {sh_ff[14:0], ser_mosi};
    if (ser_cs_n && !cs_q_ff) begin
      rx_word <= sh_ff;
      rx_count <= rx_count + 8'h01;
    end
  end
endmodule : acs_far_model

// ### acs_top_monitor.sv
`timescale 1ns/1ps
module acs_top_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ref_ext_sel,
  input wire logic normal_serial_disable,
  input wire logic ser_sclk,
  input wire logic ser_mosi,
  input wire logic ser_cs_n,
  input wire logic nv_rd_en
);
  logic sclk_q_ff;
  logic [4:0] sclk_cnt_ff;

  // ----------------------------------------------------------------
  // rising sclk count per frame
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    sclk_q_ff <= ser_sclk;
    if (!aresetn || ser_cs_n) begin
      sclk_cnt_ff <= 5'h00;
    end else if (ser_sclk && !sclk_q_ff) begin
      sclk_cnt_ff <= sclk_cnt_ff + 5'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_FRAME_BITS: assert property ($rose(ser_cs_n) |-> sclk_cnt_ff == 5'h10)
    else $error("bad frame length");
  AST_MOSI_HOLD: assert property (!ser_cs_n && ser_sclk && $past(ser_sclk) |-> $stable(ser_mosi))
    else $error("data moved while sclk high");
  AST_SCLK_IDLE: assert property (ser_cs_n |-> !ser_sclk)
    else $error("sclk outside frame");
  AST_REF_WRITE: assert property ($changed(ref_ext_sel) |-> $past(s_axi_bvalid))
    else $error("ref select moved");
  AST_CAPT_WRITE: assert property ($changed(normal_serial_disable) |-> $past(s_axi_bvalid))
    else $error("capture flag moved");
  AST_CAL_READ: assert property ($rose(aresetn) |-> ##[1:2] nv_rd_en)
    else $error("no coef read");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && !s_axi_arready)
    else $error("read not released");
  AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
endmodule : acs_top_monitor

bind acs_top acs_top_monitor acs_top_monitor_inst (.*);

// ### acs_top_bench.sv
`timescale 1ns/1ps
module acs_top_bench;
  import acs_pkg::*;
  localparam logic [11:0] VIN = 12'hA5C;
  localparam logic [13:0] OFS = 14'h0155;
  localparam logic [13:0] GAIN = 14'h2AAA;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx_count;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ext_start_n, timer2_ovf, sar_cmp_hi, converter_clock, sar_track, ref_ext_sel;
  logic normal_serial_disable, ser_sclk, ser_mosi, ser_cs_n, nv_rd_en, nv_rd_sel_gain;
  logic nv_rd_valid;
  logic [11:0] sar_dac_code;
  logic [13:0] nv_rd_data, offset_coef, gain_coef;
  logic [15:0] rx_word;
  int bad_count, n_compared, cyc;

  acs_top #(.SER_HALF(1)) acs_top_inst (.*);
  acs_far_model #(.VIN(VIN), .OFS(OFS), .GAIN(GAIN)) acs_far_model_inst (.*);

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic axw(input logic [7:0] a, input logic [7:0] dt, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, dt};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    dt = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reg_case;
    logic [31:0] d;
    logic [1:0] r;
    axr(ACS_OFF_STATUS, d, r);
    check(d & 32'h0000_0002, 32'h0000_0002);
    axr(ACS_OFF_OFS_COEF, d, r);
    check(d, {18'h0_0000, OFS});
    axr(ACS_OFF_GAIN_COEF, d, r);
    check(d, {18'h0_0000, GAIN});
    axr(ACS_OFF_CTRL_ONE, d, r);
    check(d, 32'h0000_0000);
    axr(ACS_OFF_CTRL_TWO, d, r);
    check(d, 32'h0000_0000);
    axr(8'h1C, d, r);
    check({d[29:0], r}, {30'h0, ACS_RESP_SLVERR});
    axw(ACS_OFF_RESULT, 8'h55, r);
    check(r, ACS_RESP_SLVERR);
    axw(ACS_OFF_CTRL_ONE, 8'h40, r);
    @(posedge aclk);
    check(ref_ext_sel, 1'b1);
    axw(ACS_OFF_CTRL_ONE, 8'h00, r);
    @(posedge aclk);
    check(ref_ext_sel, 1'b0);
    $display("register test done");
  endtask : reg_case

  task automatic conv_case(input logic [3:0] ch, input logic [7:0] c1, input int tr);
    logic [31:0] d;
    logic [1:0] r;
    logic cc_q = 1'b1;
    int nt = 0, nc = 0, k;
    axw(ACS_OFF_CTRL_ONE, c1, r);
    axw(ACS_OFF_CTRL_TWO, {4'h5, ch}, r);
    for (k = 0; k < 3000 && ser_cs_n; k++) begin
      @(posedge aclk);
      if (sar_track) nt++;
      else if (nt > 0 && converter_clock && !cc_q) nc++;
      cc_q = converter_clock;
    end
    for (k = 0; k < 200 && !ser_cs_n; k++) @(posedge aclk);
    @(posedge aclk);
    check(nt, tr);
    check(nc, 16);
    check(rx_word, {ch, VIN});
    check(normal_serial_disable, 1'b1);
    axr(ACS_OFF_SER_DATA, d, r);
    check(d, {16'h0000, ch, VIN});
    axr(ACS_OFF_RESULT, d, r);
    check(d, {16'h0000, ch, VIN});
    axr(ACS_OFF_CTRL_TWO, d, r);
    check(d, {24'h00_0000, 4'h4, ch});
    $display("conversion test done");
  endtask : conv_case

  task automatic trig_case(input logic [7:0] c1, input logic use_ext, input logic fire);
    logic [7:0] n0;
    logic [1:0] r;
    axw(ACS_OFF_CTRL_ONE, c1, r);
    axw(ACS_OFF_CTRL_TWO, 8'h41, r);
    n0 = rx_count;
    ext_start_n <= !use_ext;
    timer2_ovf <= !use_ext;
    repeat (use_ext ? 12 : 1) @(posedge aclk);
    {ext_start_n, timer2_ovf} <= 2'b10;
    for (int k = 0; k < 800 && rx_count == n0; k++) @(posedge aclk);
    check(32'(rx_count != n0), 32'(fire));
    $display("trigger test done");
  endtask : trig_case

  task automatic cont_case;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] n0;
    axw(ACS_OFF_CTRL_ONE, 8'h10, r);
    axw(ACS_OFF_CTRL_TWO, 8'h62, r);
    n0 = rx_count;
    for (int k = 0; k < 2000 && rx_count != n0 + 8'h04; k++) @(posedge aclk);
    check(rx_count, n0 + 8'h04);
    axr(ACS_OFF_STATUS, d, r);
    check(d & 32'h0000_0010, 32'h0000_0000);
    axw(ACS_OFF_CTRL_TWO, 8'h00, r);
    repeat (300) @(posedge aclk);
    n0 = rx_count;
    repeat (300) @(posedge aclk);
    check(rx_count, n0);
    check(normal_serial_disable, 1'b0);
    $display("continuous test done");
  endtask : cont_case

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hF;
    {ext_start_n, timer2_ovf} = 2'b10;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(posedge aclk);
    reg_case();
    conv_case(4'h3, 8'h00, 8);
    conv_case(4'h3, 8'h14, 8);
    conv_case(4'h5, 8'h28, 48);
    conv_case(4'h2, 8'h3C, 128);
    conv_case(ACS_TEMP_CHAN, 8'h10, 128);
    trig_case(8'h01, 1'b1, 1'b1);
    trig_case(8'h02, 1'b0, 1'b1);
    trig_case(8'h02, 1'b1, 1'b0);
    trig_case(8'h01, 1'b0, 1'b0);
    cont_case();
    finish_test();
  end
endmodule : acs_top_bench
